// >>> hdl/arp_pkg.sv
//------------------------------------------------------------------------------
// Purpose : Shared constants and types of the serial result port
// Assumes : 10-bit result, one system clock
// Notes   : Output positions count falling serial-clock edges after the null bit
//------------------------------------------------------------------------------
package arp_pkg;

    // -------------------------------------------------------------------------
    // Result and output sequence
    // -------------------------------------------------------------------------
    localparam int          RES_W         = 10;
    localparam logic [4:0]  POS_NULL      = 5'h00;  // Leading low bit
    localparam logic [4:0]  POS_MSB_FIRST = 5'h01;  // B9
    localparam logic [4:0]  POS_MSB_LAST  = 5'h0a;  // B0
    localparam logic [4:0]  POS_LSB_FIRST = 5'h0b;  // B0 again
    localparam logic [4:0]  POS_LSB_LAST  = 5'h14;  // B9 again
    localparam logic [4:0]  POS_FILL      = 5'h15;  // Zero fill, saturates here

    // -------------------------------------------------------------------------
    // Configuration word layout (bits after the start bit)
    // -------------------------------------------------------------------------
    localparam logic [2:0]  CFG_IDX_SGL   = 3'h0;
    localparam logic [2:0]  CFG_IDX_ODD   = 3'h1;
    localparam logic [2:0]  CFG_IDX_SEL   = 3'h2;   // First channel select bit
    localparam int          CFG_FIXED     = 3;      // Single-ended, odd/sign, order

    // -------------------------------------------------------------------------
    // Reset values
    // -------------------------------------------------------------------------
    localparam logic        RST_OE_N      = 1'b1;   // Output released
    localparam logic        RST_UNIPOLAR  = 1'b1;   // Unipolar by default
    localparam logic        RST_MSB_ONLY  = 1'b1;

    // -------------------------------------------------------------------------
    // Transfer phases
    // -------------------------------------------------------------------------
    typedef enum logic [1:0] {
        PH_WAIT,
        PH_CFG,
        PH_XMIT
    } arp_phase_t;

endpackage

// >>> hdl/arp_pins_if.sv
//------------------------------------------------------------------------------
// Purpose : Synchronised pin events passed from the pin stage to the sequencer
// Assumes : All signals on clk
// Notes   : rise and fall are one-cycle pulses
//------------------------------------------------------------------------------
`timescale 1ns/10ps
interface arp_pins_if;
    logic rise;     // Serial clock rising edge seen
    logic fall;     // Serial clock falling edge seen
    logic csLow;    // Chip select asserted
    logic dinLvl;   // Data line level, synchronised

    modport drv (output rise, output fall, output csLow, output dinLvl);
    modport rcv (input rise, input fall, input csLow, input dinLvl);
endinterface

// >>> hdl/arp_pin_sync.sv
//------------------------------------------------------------------------------
// Purpose : Two-flop synchronisers and edge detection for the serial pins
// Assumes : Pins asynchronous to clk; serial clock well below clk/4
// Notes   : First stage is read only by the second stage
//------------------------------------------------------------------------------
`timescale 1ns/10ps
module arp_pin_sync (
    // Clock and reset
    input  wire logic  clk,
    input  wire logic  reset,
    // Raw pins
    input  wire logic  csN,
    input  wire logic  sclk,
    input  wire logic  dataIn,
    // Events to the sequencer
    arp_pins_if.drv    pins
);

    typedef struct packed {
        logic [2:0] meta;   // First stage: sclk, csN, data
        logic [2:0] sync;   // Second stage
        logic       sclkD;  // Delayed sclk for edge detection
    } arp_sync_t;

    arp_sync_t sync_r;
    arp_sync_t sync_nxt;

    // -------------------------------------------------------------------------
    // Next state
    // -------------------------------------------------------------------------
    always_comb begin
        sync_nxt       = sync_r;
        sync_nxt.meta  = {sclk, csN, dataIn};
        sync_nxt.sync  = sync_r.meta;
        sync_nxt.sclkD = sync_r.sync[2];
    end

    // Register, chip select idles high
    always_ff @(posedge clk) begin
        if (reset) begin
            sync_r         <= '0;
            sync_r.meta[1] <= 1'b1;
            sync_r.sync[1] <= 1'b1;
        end else begin
            sync_r <= sync_nxt;
        end
    end

    // Edge events from second and third stages only
    assign pins.rise   = sync_r.sync[2] & ~sync_r.sclkD;
    assign pins.fall   = ~sync_r.sync[2] & sync_r.sclkD;
    assign pins.csLow  = ~sync_r.sync[1];
    assign pins.dinLvl = sync_r.sync[0];

endmodule

// >>> hdl/arp_result_port.sv
//------------------------------------------------------------------------------
// Purpose : Serial configuration input and result output of a 10-bit converter
// Assumes : Result from the converter core is valid at the null-bit fall
// Notes   : Data pin may be shared between input and output
//------------------------------------------------------------------------------
// What this block and its host do
// R1: Order bit one: MSB first, then zeros
// R2: Order bit zero: MSB first, then LSB first
// R3: Polarity bit one unipolar, zero bipolar
// R4: Without polarity bit, always unipolar
// R5: Unipolar result is straight binary
// R6: Bipolar result is two's complement
// R7: Zero fill until deselect, then release output
// R8: Host positions start bit for its word length
// R9: Four-bit host: two outputs, three inputs
// R10: Eight-bit host: one output, two inputs
// R11: Result left justified, zero fill below
// R12: Input and output may share one wire
// R13: Drive line low on fourth fall after start
// R14: Host releases line before device drives
// R15: First host byte returns B9 and B8
// R16: Second host byte returns B7 to B0
// R17: Host masks first byte with 03 hex
// R18: Host start position right justifies result
// R19: Leading zeros ignored, first one starts
// R20: Serial input sampled on rising clock
// R21: Config order: single-ended, odd/sign, selects
// R22: After config, input ignored until reselect
// R23: Output changes on falling clock edges
// R24: Deselect releases output, clears transfer state
//------------------------------------------------------------------------------
`timescale 1ns/10ps
module arp_result_port #(
    parameter int HAS_UNI  = 0,     // Polarity select bit present
    parameter int SEL_BITS = 0      // Channel select bits, 0 to 2
) (
    // Clock and reset
    input  wire logic                        clk,
    input  wire logic                        reset,
    // Serial pins
    input  wire logic                        csN,
    input  wire logic                        sclk,
    input  wire logic                        dataIn,
    output logic                             dataOut,
    output logic                             dataOeN,
    // Converter core
    input  wire logic [arp_pkg::RES_W-1:0]   convResult,
    output logic                             convRequest,
    // Decoded configuration and frame active flag
    output logic                             singleEndedSelect,
    output logic                             oddSignSelect,
    output logic [1:0]                       channelSelect,
    output logic                             polarityModeSelect,
    output logic                             bitOrderSelect,
    output logic                             frameActive
);

    localparam int         CFG_N    = arp_pkg::CFG_FIXED + SEL_BITS + HAS_UNI;
    localparam logic [2:0] CFG_LAST = 3'(CFG_N - 1);
    localparam logic [2:0] CFG_UNI  = 3'(arp_pkg::CFG_FIXED - 1 + SEL_BITS);

    typedef struct packed {
        arp_pkg::arp_phase_t         phase;
        logic [2:0]                  cfgCnt;
        logic [4:0]                  pos;
        logic [arp_pkg::RES_W-1:0]   result;
        logic                        dataOut;
        logic                        dataOeN;
        logic                        convRequest;
        logic                        sgl;
        logic                        odd;
        logic [1:0]                  sel;
        logic                        polarity_mode_select;
        logic                        bit_order_select;
        logic                        active;    // Frame in progress
    } arp_state_t;

    arp_state_t st_r;
    arp_state_t st_nxt;

    arp_pins_if pins ();

    // -------------------------------------------------------------------------
    // Pin synchronisers
    // -------------------------------------------------------------------------
    arp_pin_sync u_sync (
        .clk    (clk),
        .reset  (reset),
        .csN    (csN),
        .sclk   (sclk),
        .dataIn (dataIn),
        .pins   (pins)
    );

    // -------------------------------------------------------------------------
    // Helpers
    // -------------------------------------------------------------------------
    // Core gives offset binary in bipolar mode; flip MSB for two's complement
    function automatic logic [arp_pkg::RES_W-1:0] codeResult(
        input logic [arp_pkg::RES_W-1:0] raw,
        input logic                      polarity_mode_select
    );
        if (polarity_mode_select) begin
            codeResult = raw;                                   // [R5]
        end else begin
            codeResult = {~raw[arp_pkg::RES_W-1], raw[arp_pkg::RES_W-2:0]};  // [R6]
        end
    endfunction

    // Bit driven at a given output position
    function automatic logic outBit(
        input logic [4:0]                pos,
        input logic [arp_pkg::RES_W-1:0] res,
        input logic                      bit_order_select
    );
        logic [4:0] k;
        k = 5'h00;
        outBit = 1'b0;                                          // [R7] [R11]
        if (pos >= arp_pkg::POS_MSB_FIRST && pos <= arp_pkg::POS_MSB_LAST) begin
            k = arp_pkg::POS_MSB_LAST - pos;
            outBit = res[k[3:0]];                               // [R1] [R2] [R15] [R16]
        end else if (!bit_order_select && pos >= arp_pkg::POS_LSB_FIRST
                     && pos <= arp_pkg::POS_LSB_LAST) begin
            k = pos - arp_pkg::POS_LSB_FIRST;
            outBit = res[k[3:0]];                               // [R2]
        end
    endfunction

    // -------------------------------------------------------------------------
    // Sequencer next state
    // -------------------------------------------------------------------------
    always_comb begin
        logic [4:0] np;
        np = st_r.pos;
        st_nxt = st_r;
        st_nxt.convRequest = 1'b0;
        if (!pins.csLow) begin
            // Deselect clears transfer state, keeps configuration
            st_nxt.phase   = arp_pkg::PH_WAIT;                  // [R24]
            st_nxt.cfgCnt  = 3'h0;
            st_nxt.pos     = arp_pkg::POS_NULL;
            st_nxt.dataOut = 1'b0;
            st_nxt.dataOeN = arp_pkg::RST_OE_N;                 // [R7] [R24]
            st_nxt.active  = 1'b0;
        end else begin
            case (st_r.phase)
                arp_pkg::PH_WAIT: begin
                    // Leading zeros skipped, first one is the start bit
                    if (pins.rise && pins.dinLvl) begin         // [R19] [R20]
                        st_nxt.phase  = arp_pkg::PH_CFG;
                        st_nxt.active = 1'b1;
                        st_nxt.cfgCnt = 3'h0;
                    end
                end
                arp_pkg::PH_CFG: begin
                    if (pins.rise) begin                        // [R20]
                        // Field picked by position in the word
                        if (st_r.cfgCnt == arp_pkg::CFG_IDX_SGL) begin
                            st_nxt.sgl = pins.dinLvl;           // [R21]
                        end else if (st_r.cfgCnt == arp_pkg::CFG_IDX_ODD) begin
                            st_nxt.odd = pins.dinLvl;           // [R21]
                        end else if (st_r.cfgCnt < CFG_UNI) begin
                            st_nxt.sel = {st_r.sel[0], pins.dinLvl};  // [R21]
                        end else if (HAS_UNI != 0 && st_r.cfgCnt == CFG_UNI) begin
                            st_nxt.polarity_mode_select = pins.dinLvl;           // [R3]
                        end else begin
                            st_nxt.bit_order_select = pins.dinLvl;          // [R1] [R2]
                        end
                        if (st_r.cfgCnt == CFG_LAST) begin
                            st_nxt.phase       = arp_pkg::PH_XMIT;  // [R22]
                            st_nxt.convRequest = 1'b1;
                        end else begin
                            st_nxt.cfgCnt = st_r.cfgCnt + 3'h1;
                        end
                    end
                end
                arp_pkg::PH_XMIT: begin
                    // Input ignored here; output moves on falls only
                    if (pins.fall) begin                        // [R23]
                        if (st_r.dataOeN) begin
                            // First fall after the last config bit
                            np = arp_pkg::POS_NULL;             // [R13] [R12]
                            st_nxt.dataOeN = 1'b0;
                            st_nxt.result  = codeResult(convResult, st_r.polarity_mode_select);
                        end else if (st_r.pos != arp_pkg::POS_FILL) begin  // [R9] [R10]
                            np = st_r.pos + 5'h01;
                        end
                        st_nxt.pos     = np;
                        st_nxt.dataOut = outBit(np, st_nxt.result, st_r.bit_order_select);
                    end
                end
                default: begin
                    st_nxt.phase  = arp_pkg::PH_WAIT;
                    st_nxt.active = 1'b0;
                end
            endcase
        end
    end

    // -------------------------------------------------------------------------
    // State register
    // -------------------------------------------------------------------------
    always_ff @(posedge clk) begin
        if (reset) begin
            st_r         <= '0;
            st_r.dataOeN <= arp_pkg::RST_OE_N;
            st_r.polarity_mode_select     <= arp_pkg::RST_UNIPOLAR;              // [R4]
            st_r.bit_order_select    <= arp_pkg::RST_MSB_ONLY;
        end else begin
            st_r <= st_nxt;
        end
    end

    // Outputs straight from the state register
    assign dataOut            = st_r.dataOut;
    assign dataOeN            = st_r.dataOeN;
    assign convRequest        = st_r.convRequest;
    assign singleEndedSelect  = st_r.sgl;
    assign oddSignSelect      = st_r.odd;
    assign channelSelect      = st_r.sel;
    assign polarityModeSelect = st_r.polarity_mode_select;
    assign bitOrderSelect     = st_r.bit_order_select;
    assign frameActive        = st_r.active;

    // -------------------------------------------------------------------------
    // Checks
    // -------------------------------------------------------------------------
    default clocking cb @(posedge clk); endclocking
    default disable iff (reset);

    sequence nullFall;
        st_r.phase == arp_pkg::PH_XMIT && pins.csLow && pins.fall && st_r.dataOeN;
    endsequence

    sequence stepFall;
        st_r.phase == arp_pkg::PH_XMIT && pins.csLow && pins.fall && !st_r.dataOeN;
    endsequence

    // Rise that carries the last configuration bit
    sequence cfgDone;
        st_r.phase == arp_pkg::PH_CFG && pins.csLow && pins.rise && st_r.cfgCnt == CFG_LAST;
    endsequence

    chk_release_on_cs: assert property (!pins.csLow |=> dataOeN && !frameActive) // [R7] [R24]
        else $error("output not released after deselect");

    chk_null_low: assert property (nullFall |=> !dataOeN && !dataOut // [R13]
                                   && st_r.pos == arp_pkg::POS_NULL)
        else $error("first driven bit is not a low null");

    chk_no_early_drive: assert property (st_r.phase != arp_pkg::PH_XMIT |-> dataOeN) // [R13]
        else $error("line driven before configuration complete");

    // Position already advanced when the consequent is sampled
    chk_msb_order: assert property (stepFall ##0 (st_r.pos < arp_pkg::POS_MSB_LAST) // [R1]
        |=> dataOut == st_r.result[4'(arp_pkg::POS_MSB_LAST - st_r.pos)])
        else $error("MSB-first bit wrong");

    chk_lsb_repeat: assert property (stepFall ##0 !bitOrderSelect // [R2]
        ##0 (st_r.pos >= arp_pkg::POS_MSB_LAST && st_r.pos < arp_pkg::POS_LSB_LAST)
        |=> dataOut == st_r.result[4'(st_r.pos - arp_pkg::POS_LSB_FIRST)])
        else $error("LSB-first repeat bit wrong");

    chk_zero_fill: assert property (!dataOeN && (st_r.pos == arp_pkg::POS_FILL // [R1] [R7]
        || (bitOrderSelect && st_r.pos > arp_pkg::POS_MSB_LAST)) |-> !dataOut)
        else $error("zero fill broken");

    chk_fill_hold: assert property (stepFall ##0 (st_r.pos == arp_pkg::POS_FILL) // [R7]
        |=> st_r.pos == arp_pkg::POS_FILL && !dataOut)
        else $error("zero fill did not hold");

    chk_result_code: assert property (nullFall |=> // [R3] [R5] [R6]
        st_r.result == (polarityModeSelect
        ? $past(convResult)
        : {~$past(convResult[9]), $past(convResult[8:0])}))
        else $error("result coding wrong");

    chk_fixed_unipolar: assert property (HAS_UNI == 0 |-> polarityModeSelect) // [R4]
        else $error("bipolar selected without polarity bit");

    chk_cfg_frozen: assert property (st_r.phase == arp_pkg::PH_XMIT && pins.csLow // [R22]
        |=> $stable({singleEndedSelect, oddSignSelect, channelSelect,
                     polarityModeSelect, bitOrderSelect}))
        else $error("configuration changed after completion");

    chk_input_ignored: assert property (st_r.phase == arp_pkg::PH_XMIT && pins.csLow // [R22]
        |=> st_r.phase == arp_pkg::PH_XMIT)
        else $error("output phase left while selected");

    // One request per completed configuration
    chk_req_on_done: assert property (cfgDone // [R22]
        |=> convRequest && st_r.phase == arp_pkg::PH_XMIT)
        else $error("no conversion request after configuration");

    chk_req_single: assert property (convRequest |=> !convRequest) // [R22]
        else $error("conversion request longer than one cycle");

    chk_start_bit: assert property (st_r.phase == arp_pkg::PH_WAIT && pins.csLow // [R19] [R20]
        && !(pins.rise && pins.dinLvl) |=> st_r.phase == arp_pkg::PH_WAIT)
        else $error("transfer started without a one on a rising edge");

    chk_active_tracks: assert property (frameActive == (st_r.phase != arp_pkg::PH_WAIT)) // [R24]
        else $error("frame active flag out of step");

    chk_out_on_fall: assert property ($changed(dataOut) && pins.csLow // [R23]
        |-> $past(pins.fall))
        else $error("output changed off a falling edge");

endmodule

// >>> dv/arp_host_model.sv
//------------------------------------------------------------------------------
// Purpose : Host serial port model driving chip select, serial clock and data
// Assumes : Called from the bench just after a falling clk edge
// Notes   : Each serial clock level lasts 8 clk periods; data changes while low
//------------------------------------------------------------------------------
`timescale 1ns/10ps
module arp_host_model (
    // Clock
    input  wire logic clk,
    // Host pins
    output logic      csN,
    output logic      sclk,
    output logic      hostOut,
    output logic      hostOeN,
    // Observed lines
    input  wire logic wireLvl,
    input  wire logic auxIn,
    input  wire logic devOeN
);
    // Idle: deselected, clock low, data pin released
    initial begin
        csN     = 1'b1;
        sclk    = 1'b0;
        hostOut = 1'b0;
        hostOeN = 1'b1;
    end

    // One exchange: lead zeros, start bit, six config bits, then reads
    task automatic xfer(input int lead, input logic [5:0] cfg, input int nRise,
                        output logic [63:0] rx, output logic [63:0] rxB,
                        output logic [63:0] oe);
        int i;
        rx  = '0;
        rxB = '0;
        oe  = '0;
        @(negedge clk);
        csN     = 1'b0;
        hostOeN = 1'b0;
        for (i = 0; i < nRise; i++) begin
            if (i < lead) begin
                hostOut = 1'b0;
            end else if (i == lead) begin
                hostOut = 1'b1;
            end else if (i <= lead + 6) begin
                hostOut = cfg[6 - (i - lead)];
            end else begin
                hostOut = ~hostOut; // Noise the device must ignore
            end
            repeat (8) @(negedge clk);
            rx   = {rx[62:0], wireLvl}; // Sampled just before the rise
            rxB  = {rxB[62:0], auxIn};
            oe   = {oe[62:0], devOeN};
            sclk = 1'b1;
            repeat (8) @(negedge clk);
            sclk = 1'b0;
            if (i == lead + 3) begin
                hostOeN = 1'b1;
            end
        end
        repeat (8) @(negedge clk);
        csN     = 1'b1;
        hostOeN = 1'b1;
    endtask
endmodule

// >>> dv/test_arp_result_port.sv
//------------------------------------------------------------------------------
// Purpose : Self-checking bench for the serial result port
// Assumes : Variant A on a shared data wire, variant B with four wires
// Notes   : Variant B has the polarity bit and two channel select bits
//------------------------------------------------------------------------------
`timescale 1ns/10ps
`define CHECK(nm, exp, got) \
    begin \
        samplesChecked++; \
        if ((got) !== (exp)) begin \
            nFail++; \
            $display("MISMATCH %s expected %0h seen %0h", nm, exp, got); \
        end \
    end

module test_arp_result_port;
    // Bench signals
    logic        clk, reset, floatLvl, wireLvl;
    logic [9:0]  convResult, resB;
    logic        csN, sclk, hostOut, hostOeN;
    logic        dOutA, oeNA, reqA, sglA, oddA, polA, ordA, actA;
    logic        dOutB, oeNB, reqB, sglB, oddB, polB, ordB, actB;
    logic [1:0]  chA, chB;
    logic [63:0] rxA, rxB, oeA, eA, eB;
    int          nFail = 0, samplesChecked = 0, nReqA = 0, nReqB = 0, k, n1, n2;
    int          nActA = 0, nActB = 0, baseA, baseB;
    // Scenario table: lead zeros, config word, result, serial clock rises
    int          leadT [5] = '{1, 3, 3, 2, 0};
    logic [5:0]  cfgT  [5] = '{6'h2b, 6'h10, 6'h3d, 6'h0c, 6'h27};
    logic [9:0]  resT  [5] = '{10'h2a5, 10'h3ff, 10'h1ff, 10'h000, 10'h155};
    int          nT    [5] = '{16, 32, 20, 12, 30};

    // Clock and a toggling level for the undriven wire
    initial begin
        clk      = 1'b0;
        floatLvl = 1'b0;
        forever #12.5 clk = ~clk;
    end
    always @(negedge clk) begin
        floatLvl <= ~floatLvl;
    end
    assign wireLvl = (oeNA === 1'b0) ? dOutA : ((hostOeN === 1'b0) ? hostOut : floatLvl);

    arp_host_model u_arp_host_model (
        .clk(clk), .csN(csN), .sclk(sclk), .hostOut(hostOut), .hostOeN(hostOeN),
        .wireLvl(wireLvl), .auxIn(dOutB), .devOeN(oeNA)
    );
    arp_result_port #(.HAS_UNI(0), .SEL_BITS(0)) u_arp_result_port (
        .clk(clk), .reset(reset), .csN(csN), .sclk(sclk), .dataIn(wireLvl),
        .dataOut(dOutA), .dataOeN(oeNA), .convResult(convResult), .convRequest(reqA),
        .singleEndedSelect(sglA), .oddSignSelect(oddA), .channelSelect(chA),
        .polarityModeSelect(polA), .bitOrderSelect(ordA), .frameActive(actA)
    );
    arp_result_port #(.HAS_UNI(1), .SEL_BITS(2)) u_arp_result_port_b (
        .clk(clk), .reset(reset), .csN(csN), .sclk(sclk), .dataIn(hostOut),
        .dataOut(dOutB), .dataOeN(oeNB), .convResult(convResult), .convRequest(reqB),
        .singleEndedSelect(sglB), .oddSignSelect(oddB), .channelSelect(chB),
        .polarityModeSelect(polB), .bitOrderSelect(ordB), .frameActive(actB)
    );

    // Bus fight watch, request and active counts, sampled mid-cycle
    always @(negedge clk) begin
        if (actA === 1'b1) nActA++;
        if (actB === 1'b1) nActB++;
        if (oeNA === 1'b0 && hostOeN === 1'b0) begin
            nFail++;
            $display("MISMATCH wireConflict expected 1 seen 0");
        end
        if (reqA === 1'b1) nReqA++;
        if (reqB === 1'b1) nReqB++;
    end

    // Low n bits set
    function automatic logic [63:0] lowMask(input int n);
        return (64'h1 << n) - 64'h1;
    endfunction

    // Output stream from the null bit position on, first bit most significant
    function automatic logic [63:0] expStream(input logic [9:0] r, input logic ord,
                                              input int n);
        logic [63:0] e;
        int          j;
        e = '0;
        for (j = 0; j < n; j++) begin
            e = {e[62:0], (j >= 1 && j <= 10) ? r[10 - j] :
                          ((j >= 11 && j <= 20 && !ord) ? r[j - 11] : 1'b0)};
        end
        return e;
    endfunction

    // Counts, verdict and end of run
    task automatic final_report;
        $display("checks %0d failures %0d", samplesChecked, nFail);
        if (nFail == 0 && samplesChecked > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask

    // Main sequence: reset, then the scenario table frame by frame
    initial begin
        reset      = 1'b1;
        convResult = 10'h000;
        repeat (2) @(negedge clk);
        reset = 1'b0;
        repeat (4) @(negedge clk);
        `CHECK("resetA", 10'h106, {dOutA, oeNA, reqA, sglA, oddA, chA, polA, ordA, actA})
        `CHECK("resetB", 10'h106, {dOutB, oeNB, reqB, sglB, oddB, chB, polB, ordB, actB})
        for (k = 0; k < 5; k++) begin
            convResult = resT[k];
            baseA      = nActA;
            baseB      = nActB;
            u_arp_host_model.xfer(leadT[k], cfgT[k], nT[k], rxA, rxB, oeA);
            repeat (6) @(negedge clk);
            n1   = nT[k] - leadT[k] - 4;
            n2   = nT[k] - leadT[k] - 7;
            resB = cfgT[k][1] ? resT[k] : {~resT[k][9], resT[k][8:0]};
            eA   = expStream(resT[k], cfgT[k][3], n1);
            eB   = expStream(resB, cfgT[k][0], n2);
            `CHECK("streamA", eA, rxA & lowMask(n1))
            `CHECK("streamB", eB, rxB & lowMask(n2))
            `CHECK("driveA", lowMask(nT[k]) & ~lowMask(n1), oeA & lowMask(nT[k]))
            `CHECK("cfgA", {cfgT[k][5:4], 3'b001, cfgT[k][3]}, {sglA, oddA, chA, polA, ordA})
            `CHECK("cfgB", cfgT[k], {sglB, oddB, chB, polB, ordB})
            `CHECK("idleA", 3'b100, {oeNA, dOutA, actA})
            `CHECK("idleB", 3'b100, {oeNB, dOutB, actB})
            `CHECK("activeAB", 2'b11, {nActA > baseA, nActB > baseB})
            if (k == 0) begin
                `CHECK("byteA", {6'h00, resT[k]}, {rxA[15:8] & 8'h03, rxA[7:0]})
            end
        end
        `CHECK("reqA", 5, nReqA)
        `CHECK("reqB", 5, nReqB)
        final_report;
    end

    // Watchdog: five frames need roughly 1850 clk
    initial begin
        repeat (20000) @(posedge clk);
        nFail++;
        $display("MISMATCH watchdog expected finish seen timeout");
        final_report;
    end
endmodule
